// ==== dv/isa_mem_model.sv ====
// data memory model that keeps the bytes written by the store unit
`timescale 1ns/1ps
module isa_mem_model
    import isa_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // write strobe from the unit
    input wire isa_mem_s i_mem
);
    logic [ISA_DATA_W-1:0] mem [0:65535];

    // one byte stored per write strobe
    always @(posedge i_clk_sys) begin
        if (i_mem.we) begin
            mem[i_mem.addr] <= i_mem.data;
        end
    end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the pointer-based store unit
`timescale 1ns/1ps
module testbench
    import isa_pkg::*;
;
    typedef struct packed {
        isa_req_s req;
        logic [ISA_PTR_W-1:0] addr;
        logic pwe;
        logic [ISA_PTR_W-1:0] pval;
    } isa_row_s;

    logic i_clk_sys;
    logic i_rst;
    logic i_valid;
    isa_req_s i_req;
    logic o_ready;
    isa_mem_s o_mem;
    logic o_ptr_we;
    logic [ISA_PTR_W-1:0] o_ptr_val;
    logic o_flag_we;
    logic o_done;
    int num_errors = 0;
    int checks_done = 0;
    isa_row_s rows [7];

    isa_store_unit dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_valid(i_valid),
        .i_req(i_req), .o_ready(o_ready), .o_mem(o_mem), .o_ptr_we(o_ptr_we),
        .o_ptr_val(o_ptr_val), .o_flag_we(o_flag_we), .o_done(o_done));
    isa_mem_model mem_model (.i_clk_sys(i_clk_sys), .i_mem(o_mem));

    // free-running clock
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // bounded wait for an idle unit
    task automatic wait_ready();
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 20) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (o_ready !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // one store; poke keeps valid up with bogus data while busy
    task automatic store(input isa_row_s r, input logic poke);
        wait_ready();
        i_req = r.req;
        i_valid = 1'b1;
        @(negedge i_clk_sys);
        i_valid = poke;
        i_req.source_register = ~r.req.source_register;
        check(o_ready, 1'b0);
        check(o_mem.addr, r.addr);
        check(o_mem.data, r.req.source_register);
        @(negedge i_clk_sys);
        check(o_mem.we, 1'b1);
        check(o_ptr_we, r.pwe);
        check(o_flag_we, 1'b0);
        if (r.pwe) begin
            check(o_ptr_val, r.pval);
        end
        @(negedge i_clk_sys);
        // only a poked store still holds valid here; the next store raises it again
        if (poke) begin
            i_valid = 1'b0;
        end
        check({o_mem.we, o_done, o_ready}, 3'h3);
        check(mem_model.mem[r.addr], r.req.source_register);
    endtask

    initial begin
        // store forms with wrap and full offset cases
        rows[0] = '{'{ISA_PLAIN_Z, 8'hA5, 6'h3F, 16'h1111, 16'h1234}, 16'h1234, 1'b0, 16'h0};
        rows[1] = '{'{ISA_POST_INC_Z, 8'h5A, 6'h01, 16'h0, 16'h1234}, 16'h1234, 1'b1, 16'h1235};
        rows[2] = '{'{ISA_POST_INC_Z, 8'h0F, 6'h00, 16'h0, 16'hFFFF}, 16'hFFFF, 1'b1, 16'h0000};
        rows[3] = '{'{ISA_PRE_DEC_Z, 8'hC3, 6'h02, 16'h2222, 16'h1000}, 16'h0FFF, 1'b1, 16'h0FFF};
        rows[4] = '{'{ISA_PRE_DEC_Z, 8'hE1, 6'h00, 16'h0, 16'h0000}, 16'hFFFF, 1'b1, 16'hFFFF};
        rows[5] = '{'{ISA_DISP_Y, 8'h3C, 6'h3F, 16'hFFF0, 16'h4444}, 16'h002F, 1'b0, 16'h0};
        rows[6] = '{'{ISA_DISP_Z, 8'h96, 6'h3F, 16'h5555, 16'h8000}, 16'h803F, 1'b0, 16'h0};
        i_rst = 1'b1;
        i_valid = 1'b0;
        i_req = '0;
        repeat (2) @(negedge i_clk_sys);
        check({o_ready, o_mem.we, o_ptr_we, o_done, o_flag_we}, 5'h10);
        i_rst = 1'b0;
        // back-to-back stores at full rate
        foreach (rows[i]) begin
            store(rows[i], 1'b0);
        end
        // request during busy is dropped, not queued
        store(rows[6], 1'b1);
        repeat (3) begin
            @(negedge i_clk_sys);
            check({o_mem.we, o_ready}, 2'h1);
        end
        // unused mode code acts as a plain z store, pointer untouched
        store('{'{isa_mode_e'(3'h7), 8'h77, 6'h05, 16'h1357, 16'h2468}, 16'h2468, 1'b0,
            16'h0}, 1'b0);
        // second reset clears the write port
        i_rst = 1'b1;
        @(negedge i_clk_sys);
        check({o_mem.addr, o_mem.data, o_ptr_val}, 40'h0);
        i_rst = 1'b0;
        store(rows[1], 1'b0);
        tally_and_finish();
    end
endmodule

// ==== inc/isa_pkg.sv ====
// package for the indirect store addressing unit: modes, carriers and counts
package isa_pkg;

    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int ISA_PTR_W = 16;
    localparam int ISA_DATA_W = 8;
    localparam int ISA_DISP_W = 6;
    localparam int ISA_STORE_CYCLES = 2; // busy cycles of every store form
    localparam logic [ISA_PTR_W-1:0] ISA_PTR_ONE = 16'h0001;
    localparam logic [ISA_PTR_W-1:0] ISA_ADDR_RST = 16'h0000;
    localparam logic [ISA_DATA_W-1:0] ISA_DATA_RST = 8'h00;

    // ------------------------------------------------------------
    // store forms
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ISA_PLAIN_Z,
        ISA_POST_INC_Z,
        ISA_PRE_DEC_Z,
        ISA_DISP_Y,
        ISA_DISP_Z
    } isa_mode_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // one decoded store_indirect_op or store_displacement_op
    typedef struct packed {
        isa_mode_e mode;
        logic [ISA_DATA_W-1:0] source_register;
        logic [ISA_DISP_W-1:0] q;
        logic [ISA_PTR_W-1:0] y_ptr;
        logic [ISA_PTR_W-1:0] z_ptr;
    } isa_req_s;

    // result of address generation
    typedef struct packed {
        logic [ISA_PTR_W-1:0] addr;
        logic [ISA_PTR_W-1:0] ptr_next;
        logic ptr_we;
    } isa_addr_s;

    // data memory write strobe
    typedef struct packed {
        logic we;
        logic [ISA_PTR_W-1:0] addr;
        logic [ISA_DATA_W-1:0] data;
    } isa_mem_s;

endpackage

// ==== verilog/isa_addr_gen.sv ====
// address and pointer update generation for the store forms
`timescale 1ns/1ps
module isa_addr_gen
    import isa_pkg::*;
(
    // decoded store
    input wire isa_req_s i_req,
    // computed address and pointer update
    output isa_addr_s o_addr
);

    logic [ISA_PTR_W-1:0] disp_ext;
    logic [ISA_PTR_W-1:0] z_inc;
    logic [ISA_PTR_W-1:0] z_dec;

    // ------------------------------------------------------------
    // pointer arithmetic, wraps in 16 bits
    // ------------------------------------------------------------
    assign disp_ext = {{(ISA_PTR_W-ISA_DISP_W){1'b0}}, i_req.q}; // unsigned q
    assign z_inc = ISA_PTR_W'(i_req.z_ptr + ISA_PTR_ONE);
    assign z_dec = ISA_PTR_W'(i_req.z_ptr - ISA_PTR_ONE);

    // form select
    always_comb begin
        o_addr.addr = i_req.z_ptr;
        o_addr.ptr_next = i_req.z_ptr;
        o_addr.ptr_we = 1'b0;
        unique case (i_req.mode)
            ISA_PLAIN_Z: begin
                o_addr.addr = i_req.z_ptr; // z kept
            end
            ISA_POST_INC_Z: begin
                o_addr.addr = i_req.z_ptr; // write old z, then bump
                o_addr.ptr_next = z_inc;
                o_addr.ptr_we = 1'b1;
            end
            ISA_PRE_DEC_Z: begin
                o_addr.addr = z_dec; // drop first, then write
                o_addr.ptr_next = z_dec;
                o_addr.ptr_we = 1'b1;
            end
            ISA_DISP_Y: begin
                o_addr.addr = ISA_PTR_W'(i_req.y_ptr + disp_ext);
            end
            ISA_DISP_Z: begin
                o_addr.addr = ISA_PTR_W'(i_req.z_ptr + disp_ext);
            end
            default: begin
                o_addr.ptr_we = 1'b0; // illegal code: plain, no pointer change
            end
        endcase
    end

endmodule

// ==== verilog/isa_store_unit.sv ====
// execution unit for pointer-based stores into data memory
// no store form ever writes the status flags; o_flag_we stays low.
`timescale 1ns/1ps
module isa_store_unit
    import isa_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // store request from the decoder
    input wire logic i_valid,
    input wire isa_req_s i_req,
    output logic o_ready,
    // data memory write port
    output isa_mem_s o_mem,
    // z pointer write back to the register file
    output logic o_ptr_we,
    output logic [ISA_PTR_W-1:0] o_ptr_val,
    // status flag write enable, always low for stores
    output logic o_flag_we,
    // completion pulse
    output logic o_done
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ISA_S_IDLE,
        ISA_S_ADDR,
        ISA_S_WRITE
    } isa_state_e;

    typedef struct packed {
        isa_state_e st;
        logic ready;
        isa_mem_s mem;
        logic ptr_we_pend;
        logic ptr_we;
        logic [ISA_PTR_W-1:0] ptr_val;
        logic flag_we;
        logic done;
    } isa_regs_s;

    localparam isa_regs_s ISA_REGS_RST = '{
        st: ISA_S_IDLE,
        ready: 1'b1,
        mem: '{we: 1'b0, addr: ISA_ADDR_RST, data: ISA_DATA_RST},
        ptr_we_pend: 1'b0,
        ptr_we: 1'b0,
        ptr_val: ISA_ADDR_RST,
        flag_we: 1'b0,
        done: 1'b0
    };

    isa_regs_s r_q;
    isa_regs_s r_d;
    isa_addr_s agen;
    logic accept;

    // ------------------------------------------------------------
    // address generation
    // ------------------------------------------------------------
    isa_addr_gen u_addr_gen (
        .i_req(i_req),
        .o_addr(agen)
    );

    assign accept = i_valid && r_q.ready;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.mem.we = 1'b0;
        r_d.ptr_we = 1'b0;
        r_d.flag_we = 1'b0; // stores never touch flags
        unique case (r_q.st)
            ISA_S_IDLE: begin
                if (accept) begin
                    // first cycle: capture address, data and pointer update
                    r_d.st = ISA_S_ADDR;
                    r_d.ready = 1'b0;
                    r_d.mem.addr = agen.addr;
                    r_d.mem.data = i_req.source_register;
                    r_d.ptr_val = agen.ptr_next;
                    r_d.ptr_we_pend = agen.ptr_we;
                end
            end
            ISA_S_ADDR: begin
                // second cycle: write strobe and pointer write back together
                r_d.st = ISA_S_WRITE;
                r_d.mem.we = 1'b1;
                r_d.ptr_we = r_q.ptr_we_pend;
            end
            ISA_S_WRITE: begin
                r_d.st = ISA_S_IDLE;
                r_d.ready = 1'b1;
                r_d.done = 1'b1;
                r_d.ptr_we_pend = 1'b0;
            end
        endcase
    end

    // register the state
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r_q <= ISA_REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the registers
    // ------------------------------------------------------------
    assign o_ready = r_q.ready;
    assign o_mem = r_q.mem;
    assign o_ptr_we = r_q.ptr_we;
    assign o_ptr_val = r_q.ptr_val;
    assign o_flag_we = r_q.flag_we;
    assign o_done = r_q.done;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence take_s(isa_mode_e m);
        accept && (i_req.mode == m);
    endsequence

    sequence two_cycle_s;
        !o_ready && !o_mem.we ##1 !o_ready && o_mem.we ##1 o_ready && o_done && !o_mem.we;
    endsequence

    store_timing_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        accept |=> two_cycle_s)
        else $error("store did not finish in two cycles");

    plain_z_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        take_s(ISA_PLAIN_Z) |-> ##2 o_mem.we && (o_mem.addr == $past(i_req.z_ptr, 2))
        && (o_mem.data == $past(i_req.source_register, 2)) && !o_ptr_we)
        else $error("plain store address or pointer wrong");

    post_inc_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        take_s(ISA_POST_INC_Z) |-> ##2 o_mem.we && o_ptr_we
        && (o_mem.addr == $past(i_req.z_ptr, 2))
        && (o_ptr_val == ISA_PTR_W'($past(i_req.z_ptr, 2) + ISA_PTR_ONE)))
        else $error("post-increment store wrong");

    pre_dec_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        take_s(ISA_PRE_DEC_Z) |-> ##2 o_mem.we && o_ptr_we && (o_ptr_val == o_mem.addr)
        && (o_mem.addr == ISA_PTR_W'($past(i_req.z_ptr, 2) - ISA_PTR_ONE)))
        else $error("pre-decrement store wrong");

    disp_y_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        take_s(ISA_DISP_Y) |-> ##2 o_mem.we && !o_ptr_we && (o_mem.addr
        == ISA_PTR_W'($past(i_req.y_ptr, 2) + {10'h000, $past(i_req.q, 2)})))
        else $error("y displacement store wrong");

    disp_z_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        take_s(ISA_DISP_Z) |-> ##2 o_mem.we && !o_ptr_we && (o_mem.addr
        == ISA_PTR_W'($past(i_req.z_ptr, 2) + {10'h000, $past(i_req.q, 2)})))
        else $error("z displacement store wrong");

    ptr_wrap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        take_s(ISA_POST_INC_Z) ##0 (i_req.z_ptr == 16'hFFFF) |-> ##2 (o_ptr_val == 16'h0000))
        else $error("pointer increment did not wrap");

    no_flags_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_mem.we || o_ptr_we || o_done) |-> !o_flag_we)
        else $error("store touched status flags");

    ptr_only_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_ptr_we |-> o_mem.we && $rose(o_mem.we))
        else $error("pointer write outside write cycle");

endmodule
